// ### hw/fault_status_pkg.sv
package fault_status_pkg;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [6:0] THERMAL_STATUS_ADDR   = 7'h42;
	localparam logic [6:0] DEVICE_STATUS_ADDR    = 7'h43;
	localparam logic [6:0] BUS_FAULT_STATUS_ADDR = 7'h44;

	// ************************************************************
	// Field positions and masks
	// ************************************************************
	localparam int unsigned SHUT2_BIT     = 2;
	localparam int unsigned SHUT1_BIT     = 1;
	localparam int unsigned PREWARN_BIT   = 0;
	localparam int unsigned PREV_LSB      = 6;
	localparam int unsigned WDCNT_LSB     = 2;
	localparam int unsigned SPI_FAIL_BIT  = 1;
	localparam int unsigned FAILURE_BIT   = 0;
	localparam int unsigned LIN1_LSB      = 5;
	localparam int unsigned CAN_LSB       = 1;
	localparam int unsigned CAN_UV_BIT    = 0;

	localparam logic [7:0] THERMAL_VALID_MASK = 8'h07;
	localparam logic [7:0] DEVICE_VALID_MASK  = 8'hCF;
	localparam logic [7:0] BUS_VALID_MASK     = 8'h67;
	localparam logic [7:0] DEVICE_HW_MASK     = 8'h0C;

	// ************************************************************
	// Reset and restart values
	// ************************************************************
	localparam logic [7:0] STATUS_RESET_VALUE  = 8'h00;
	localparam logic [7:0] THERMAL_RESTART_KEEP = 8'h07;
	localparam logic [7:0] DEVICE_RESTART_KEEP  = 8'hCF;
	localparam logic [7:0] BUS_RESTART_KEEP     = 8'h67;

	// ************************************************************
	// Encodings
	// ************************************************************
	typedef enum logic [1:0] {
		PREV_CLEARED = 2'b00,
		PREV_FAILURE = 2'b01,
		PREV_SLEEP   = 2'b10
	} prev_state_t;

	localparam logic [1:0] WDCNT_ZERO = 2'h0;
	localparam logic [1:0] WDCNT_ONE  = 2'h1;
	localparam logic [1:0] WDCNT_MAX  = 2'h2;

	localparam logic [2:0] CONFIG_0 = 3'h0;
	localparam logic [2:0] CONFIG_2 = 3'h2;
	localparam logic [2:0] CONFIG_4 = 3'h4;

	// ************************************************************
	// Carriers
	// ************************************************************
	typedef struct packed {
		logic       valid;
		logic       clear;
		logic [6:0] addr;
	} cmd_t;

	typedef struct packed {
		logic       thermal_shutdown_level2;
		logic       thermal_shutdown_level1;
		logic       thermal_prewarning;
		logic       spi_invalid;
		logic       fail_output_ext;
		logic       illegal_sleep;
		logic       sleep_uncleared_wake;
		logic       sleep_exit;
		logic       failure_restart;
	} fault_evt_t;

	typedef struct packed {
		logic       lin_valid;
		logic [1:0] lin_code;
		logic       can_valid;
		logic [1:0] can_code;
	} bus_evt_t;

endpackage : fault_status_pkg

// ### hw/sbc_fault_status_regs.sv
`timescale 1ns/1ns
module sbc_fault_status_regs
	import fault_status_pkg::*;
(
	input  wire logic                          CORE_CLK_I,
	input  wire logic                          SYS_RST_I,
	input  wire logic                          SOFT_RST_I,
	input  wire logic                          RESTART_I,
	input  wire fault_status_pkg::cmd_t        CMD_I,
	input  wire fault_status_pkg::fault_evt_t  EVT_I,
	input  wire fault_status_pkg::bus_evt_t    BUS_EVT_I,
	input  wire logic                          CAN_SUPPLY_LOW_I,
	input  wire logic                          CAN_MODE1_I,
	input  wire logic [2:0]                    CONFIG_I,
	input  wire logic                          WD_ERR_I,
	input  wire logic                          WD_OK_I,
	input  wire logic                          WD_STOP_I,
	input  wire logic                          WD_STOP_BY_FAIL_I,
	output logic [7:0]                         RD_DATA_O,
	output logic                               RD_VALID_O,
	output logic                               FAIL_OUT_O,
	output logic                               FAILSAFE_REQ_O,
	output logic                               WD_RESTART_O,
	output logic                               CAN_TX_OFF_O
);
	import fault_status_pkg::*;

	// ************************************************************
	// State
	// ************************************************************
	logic [7:0] therm_q, therm_d;
	logic [7:0] dev_q, dev_d;
	logic [7:0] bus_q, bus_d;
	logic       frozen_q, frozen_d;
	logic       failout_q, failout_d;
	logic       fs_q, fs_d;
	logic       wdrst_q, wdrst_d;
	logic       cantx_q, cantx_d;
	logic [7:0] rdata_q, rdata_d;
	logic       rvalid_q, rvalid_d;

	logic       clr_therm, clr_dev, clr_bus;
	logic       can_uv;
	logic       fail_evt;
	logic [1:0] cnt;
	logic [1:0] thr;

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		clr_therm = CMD_I.valid && CMD_I.clear && CMD_I.addr == THERMAL_STATUS_ADDR;
		clr_dev   = CMD_I.valid && CMD_I.clear && CMD_I.addr == DEVICE_STATUS_ADDR;
		clr_bus   = CMD_I.valid && CMD_I.clear && CMD_I.addr == BUS_FAULT_STATUS_ADDR;
		// Comparator output ignored while CAN_MODE1_I is low, outside the CAN mode that powers it
		can_uv    = CAN_SUPPLY_LOW_I && CAN_MODE1_I;
		therm_d   = therm_q;
		dev_d     = dev_q;
		bus_d     = bus_q;
		frozen_d  = frozen_q;
		failout_d = failout_q;
		fs_d      = EVT_I.thermal_shutdown_level2;
		wdrst_d   = 1'b0;
		cantx_d   = can_uv;
		fail_evt  = 1'b0;
		cnt       = dev_q[WDCNT_LSB +: 2];
		thr       = (CONFIG_I == CONFIG_2) ? WDCNT_ONE : WDCNT_MAX;

		if (RESTART_I) begin
			therm_d = therm_d & THERMAL_RESTART_KEEP;
			dev_d   = dev_d & DEVICE_RESTART_KEEP;
			bus_d   = bus_d & BUS_RESTART_KEEP;
		end

		// Clears first so that same-cycle events below win
		if (clr_therm) begin
			therm_d = STATUS_RESET_VALUE;
		end
		if (clr_dev) begin
			dev_d = dev_d & DEVICE_HW_MASK;
		end
		if (clr_bus) begin
			bus_d = STATUS_RESET_VALUE;
		end

		therm_d[SHUT2_BIT]   = therm_d[SHUT2_BIT] | EVT_I.thermal_shutdown_level2;
		therm_d[SHUT1_BIT]   = therm_d[SHUT1_BIT] | EVT_I.thermal_shutdown_level1;
		therm_d[PREWARN_BIT] = therm_d[PREWARN_BIT] | EVT_I.thermal_prewarning;

		dev_d[SPI_FAIL_BIT] = dev_d[SPI_FAIL_BIT] | EVT_I.spi_invalid;

		// Watchdog failure counter, the only self-maintained field
		if (WD_OK_I) begin
			cnt      = WDCNT_ZERO;
			frozen_d = 1'b0;
		end else if (WD_ERR_I) begin
			wdrst_d = 1'b1;
			if (cnt != WDCNT_MAX) begin
				cnt = cnt + WDCNT_ONE;
			end
			if (CONFIG_I == CONFIG_2 || CONFIG_I == CONFIG_4) begin
				frozen_d = 1'b1;
			end
			// Config 0 threshold is two, so a first failure only restarts
			if (cnt >= thr) begin
				fail_evt = 1'b1;
			end
		end else if (WD_STOP_I && !WD_STOP_BY_FAIL_I && !frozen_q) begin
			cnt = WDCNT_ZERO;
		end
		dev_d[WDCNT_LSB +: 2] = cnt;

		if (fail_evt || EVT_I.fail_output_ext) begin
			failout_d          = 1'b1;
			dev_d[FAILURE_BIT] = 1'b1;
		end

		// Failure cause outranks a sleep cause in the same cycle
		if (WD_ERR_I || EVT_I.thermal_shutdown_level2 || EVT_I.failure_restart
			|| EVT_I.illegal_sleep) begin
			dev_d[PREV_LSB +: 2] = PREV_FAILURE;
		end else if (EVT_I.sleep_uncleared_wake || EVT_I.sleep_exit) begin
			dev_d[PREV_LSB +: 2] = PREV_SLEEP;
		end

		if (BUS_EVT_I.lin_valid) begin
			bus_d[LIN1_LSB +: 2] = BUS_EVT_I.lin_code;
		end
		if (BUS_EVT_I.can_valid) begin
			bus_d[CAN_LSB +: 2] = BUS_EVT_I.can_code;
		end
		bus_d[CAN_UV_BIT] = bus_d[CAN_UV_BIT] | can_uv;

		therm_d = therm_d & THERMAL_VALID_MASK;
		dev_d   = dev_d & DEVICE_VALID_MASK;
		bus_d   = bus_d & BUS_VALID_MASK;

		if (SOFT_RST_I) begin
			therm_d   = STATUS_RESET_VALUE;
			dev_d     = STATUS_RESET_VALUE;
			bus_d     = STATUS_RESET_VALUE;
			frozen_d  = 1'b0;
			failout_d = 1'b0;
		end
	end

	// ************************************************************
	// Read path
	// ************************************************************
	always_comb begin
		rvalid_d = CMD_I.valid;
		rdata_d  = STATUS_RESET_VALUE;
		// Byte returned is the content before any clear of this command
		case (CMD_I.addr)
			THERMAL_STATUS_ADDR: begin
				rdata_d = therm_q;
			end
			DEVICE_STATUS_ADDR: begin
				rdata_d = dev_q;
			end
			BUS_FAULT_STATUS_ADDR: begin
				rdata_d = bus_q;
			end
			default: begin
				rdata_d = STATUS_RESET_VALUE;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			therm_q  <= STATUS_RESET_VALUE;
			dev_q    <= STATUS_RESET_VALUE;
			bus_q    <= STATUS_RESET_VALUE;
			frozen_q <= 1'b0;
			failout_q <= 1'b0;
			fs_q     <= 1'b0;
			wdrst_q  <= 1'b0;
			cantx_q  <= 1'b0;
			rdata_q  <= STATUS_RESET_VALUE;
			rvalid_q <= 1'b0;
		end else begin
			therm_q  <= therm_d;
			dev_q    <= dev_d;
			bus_q    <= bus_d;
			frozen_q <= frozen_d;
			failout_q <= failout_d;
			fs_q     <= fs_d;
			wdrst_q  <= wdrst_d;
			cantx_q  <= cantx_d;
			rdata_q  <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	assign RD_DATA_O      = rdata_q;
	assign RD_VALID_O     = rvalid_q;
	assign FAIL_OUT_O     = failout_q;
	assign FAILSAFE_REQ_O = fs_q;
	assign WD_RESTART_O   = wdrst_q;
	assign CAN_TX_OFF_O   = cantx_q;

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (SYS_RST_I);

	sequence s_sleep_cause;
		EVT_I.sleep_uncleared_wake && !EVT_I.illegal_sleep && !EVT_I.failure_restart;
	endsequence

	sequence s_no_fail_cause;
		!WD_ERR_I && !EVT_I.thermal_shutdown_level2 && !SOFT_RST_I;
	endsequence

	a_reserved_zero: assert property ((therm_q[7:3] == 5'h00) && (dev_q[5:4] == 2'h0)
		&& bus_q[7] == 1'b0 && bus_q[4:3] == 2'h0) else $error("reserved bit set");
	a_shut2_failsafe: assert property (EVT_I.thermal_shutdown_level2 && !SOFT_RST_I
		|=> therm_q[SHUT2_BIT] && FAILSAFE_REQ_O) else $error("level2 not latched");
	a_shut1_latch: assert property (EVT_I.thermal_shutdown_level1 && !SOFT_RST_I
		|=> therm_q[SHUT1_BIT]) else $error("level1 not latched");
	a_prewarn_sticky: assert property (therm_q[PREWARN_BIT] && !clr_therm && !SOFT_RST_I
		|=> therm_q[PREWARN_BIT]) else $error("prewarning lost without clear");
	a_prev_legal: assert property (dev_q[PREV_LSB +: 2] != 2'b11)
		else $error("previous state reads 11");
	a_illegal_sleep: assert property (EVT_I.illegal_sleep && !SOFT_RST_I
		|=> dev_q[PREV_LSB +: 2] == PREV_FAILURE) else $error("illegal sleep not failure");
	a_sleep_uncleared: assert property (s_sleep_cause ##0 s_no_fail_cause
		|=> dev_q[PREV_LSB +: 2] == PREV_SLEEP) else $error("sleep cause lost");
	a_wd_count_range: assert property (dev_q[WDCNT_LSB +: 2] != 2'h3)
		else $error("watchdog count reached 3");
	a_wd_ok_clear: assert property (WD_OK_I |=> dev_q[WDCNT_LSB +: 2] == WDCNT_ZERO)
		else $error("good trigger did not clear count");
	a_cfg0_first: assert property (CONFIG_I == CONFIG_0 && WD_ERR_I && !WD_OK_I
		&& dev_q[WDCNT_LSB +: 2] == WDCNT_ZERO && !failout_q && !EVT_I.fail_output_ext
		|=> !FAIL_OUT_O && WD_RESTART_O) else $error("config 0 first failure misfired");
	a_spi_fail_set: assert property (EVT_I.spi_invalid && !SOFT_RST_I
		|=> dev_q[SPI_FAIL_BIT]) else $error("spi fail not set");
	a_can_uv: assert property (CAN_SUPPLY_LOW_I && CAN_MODE1_I && !SOFT_RST_I
		|=> bus_q[CAN_UV_BIT] && CAN_TX_OFF_O) else $error("can undervoltage missed");
	a_can_uv_gated: assert property (!CAN_MODE1_I |=> !CAN_TX_OFF_O)
		else $error("monitor active outside can mode");
	a_clear_keeps: assert property (clr_dev && !WD_ERR_I && !WD_OK_I && !WD_STOP_I
		&& !SOFT_RST_I |=> dev_q[WDCNT_LSB +: 2] == $past(dev_q[WDCNT_LSB +: 2]))
		else $error("clear touched watchdog count");
	a_prewarn_latch: assert property (EVT_I.thermal_prewarning && !SOFT_RST_I
		|=> therm_q[PREWARN_BIT])
		else $error("prewarning not latched");
	// Without a clear no thermal flag may fall, whatever the temperature does now
	a_therm_sticky: assert property (!clr_therm && !SOFT_RST_I
		|=> (therm_q & $past(therm_q)) == $past(therm_q)) else $error("thermal flag lost");
	a_sleep_exit: assert property (EVT_I.sleep_exit && !EVT_I.illegal_sleep
		&& !EVT_I.failure_restart ##0 s_no_fail_cause |=> dev_q[PREV_LSB +: 2] == PREV_SLEEP)
		else $error("sleep exit not reported");
	a_fail_restart: assert property (EVT_I.failure_restart && !SOFT_RST_I
		|=> dev_q[PREV_LSB +: 2] == PREV_FAILURE)
		else $error("failure restart not reported");
	a_cfg2_first: assert property (CONFIG_I == CONFIG_2 && WD_ERR_I && !WD_OK_I
		&& !SOFT_RST_I |=> FAIL_OUT_O && dev_q[FAILURE_BIT] && dev_q[WDCNT_LSB +: 2] != WDCNT_ZERO)
		else $error("config 2 failure missed");
	a_wd_stop_clear: assert property (WD_STOP_I && !WD_STOP_BY_FAIL_I && !frozen_q
		&& !WD_ERR_I |=> dev_q[WDCNT_LSB +: 2] == WDCNT_ZERO)
		else $error("watchdog stop did not clear count");
	a_wd_frozen: assert property (WD_STOP_I && frozen_q && !WD_ERR_I && !WD_OK_I
		&& !SOFT_RST_I |=> dev_q[WDCNT_LSB +: 2] == $past(dev_q[WDCNT_LSB +: 2]))
		else $error("frozen count changed on stop");
	a_fail_ext: assert property (EVT_I.fail_output_ext && !SOFT_RST_I
		|=> dev_q[FAILURE_BIT] && FAIL_OUT_O)
		else $error("fail output flag missed");
	a_lin_code: assert property (BUS_EVT_I.lin_valid && !SOFT_RST_I
		|=> bus_q[LIN1_LSB +: 2] == $past(BUS_EVT_I.lin_code))
		else $error("lin code not loaded");
	a_can_code: assert property (BUS_EVT_I.can_valid && !SOFT_RST_I
		|=> bus_q[CAN_LSB +: 2] == $past(BUS_EVT_I.can_code))
		else $error("can code not loaded");
	a_soft_clear: assert property (SOFT_RST_I
		|=> therm_q == STATUS_RESET_VALUE && dev_q == STATUS_RESET_VALUE
		&& bus_q == STATUS_RESET_VALUE) else $error("soft reset left a flag");
	a_read_answer: assert property (CMD_I.valid && CMD_I.addr == THERMAL_STATUS_ADDR
		|=> RD_VALID_O && RD_DATA_O == $past(therm_q)) else $error("read answer wrong");
	a_clear_therm: assert property (clr_therm && !SOFT_RST_I && !EVT_I.thermal_prewarning
		&& !EVT_I.thermal_shutdown_level1 && !EVT_I.thermal_shutdown_level2
		|=> therm_q == STATUS_RESET_VALUE) else $error("thermal clear incomplete");

endmodule : sbc_fault_status_regs

// ### test/host_model.sv
`timescale 1ns/1ns
module host_model (
	input  wire logic                   clk_i,
	input  wire logic [7:0]             rd_data_i,
	input  wire logic                   rd_valid_i,
	output fault_status_pkg::cmd_t      cmd_o
);
	import fault_status_pkg::*;

	// ************************************************************
	// Command issue
	// ************************************************************
	initial cmd_o = '0;

	// Held across the taking edge; answer is sampled one cycle later
	task automatic xfer(input logic clr, input logic [6:0] addr, output logic [7:0] data,
		output logic ok);
		@(negedge clk_i);
		cmd_o = '{valid: 1'b1, clear: clr, addr: addr};
		@(negedge clk_i);
		cmd_o = '0;
		data = rd_data_i;
		ok = rd_valid_i;
	endtask : xfer
endmodule : host_model

// ### test/sbc_fault_status_regs_tb.sv
`timescale 1ns/1ns
module sbc_fault_status_regs_tb;
	import fault_status_pkg::*;
	logic       clk = 1'b0;
	logic       rst;
	logic [1:0] ctl;
	logic       can_low;
	logic       can_mode1;
	logic [2:0] wd;
	logic       wd_stop_fail;
	logic [2:0] config_sel;
	fault_evt_t evt;
	bus_evt_t   bus_evt;
	cmd_t       cmd;
	logic [7:0] rd_data;
	logic       rd_valid;
	logic       fail_out;
	logic       failsafe_req;
	logic       wd_restart;
	logic       can_tx_off;
	int         error_cnt = 0;
	int         comparisons = 0;

	always #2 clk = ~clk;

	sbc_fault_status_regs sbc_fault_status_regs_i (
		.CORE_CLK_I(clk), .SYS_RST_I(rst), .SOFT_RST_I(ctl[1]), .RESTART_I(ctl[0]),
		.CMD_I(cmd), .EVT_I(evt), .BUS_EVT_I(bus_evt), .CAN_SUPPLY_LOW_I(can_low),
		.CAN_MODE1_I(can_mode1), .CONFIG_I(config_sel), .WD_ERR_I(wd[0]), .WD_OK_I(wd[1]),
		.WD_STOP_I(wd[2]), .WD_STOP_BY_FAIL_I(wd_stop_fail), .RD_DATA_O(rd_data),
		.RD_VALID_O(rd_valid), .FAIL_OUT_O(fail_out), .FAILSAFE_REQ_O(failsafe_req),
		.WD_RESTART_O(wd_restart), .CAN_TX_OFF_O(can_tx_off)
	);

	host_model host_model_i (
		.clk_i(clk), .rd_data_i(rd_data), .rd_valid_i(rd_valid), .cmd_o(cmd)
	);

	// ************************************************************
	// Compare and access tasks
	// ************************************************************
	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check8

	task automatic check1(input logic got, input logic exp);
		check8({7'h00, got}, {7'h00, exp});
	endtask : check1

	task automatic access(input logic clr, input logic [6:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic       v;
		host_model_i.xfer(clr, a, d, v);
		check1(v, 1'b1);
		check8(d, exp);
	endtask : access

	// Pulses last one cycle, so every flag is seen as a latched event
	task automatic fire(input fault_evt_t e);
		@(negedge clk);
		evt = e;
		@(negedge clk);
		evt = '0;
	endtask : fire

	task automatic wd_pulse(input logic [2:0] k);
		@(negedge clk);
		wd = k;
		@(negedge clk);
		wd = 3'h0;
	endtask : wd_pulse

	task automatic ctl_pulse(input logic [1:0] k);
		@(negedge clk);
		ctl = k;
		@(negedge clk);
		ctl = 2'h0;
	endtask : ctl_pulse

	task automatic give_verdict;
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : give_verdict

	// ************************************************************
	// Tests
	// ************************************************************
	initial begin
		{ctl, can_low, can_mode1, wd, wd_stop_fail} = '0;
		config_sel = CONFIG_0;
		evt = '0;
		bus_evt = '0;
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		access(1'b0, THERMAL_STATUS_ADDR, 8'h00);
		access(1'b0, DEVICE_STATUS_ADDR, 8'h00);
		access(1'b0, BUS_FAULT_STATUS_ADDR, 8'h00);
		fire(9'h100);
		check1(failsafe_req, 1'b1);
		access(1'b0, THERMAL_STATUS_ADDR, 8'h04);
		fire(9'h080);
		access(1'b0, THERMAL_STATUS_ADDR, 8'h06);
		fire(9'h040);
		access(1'b0, THERMAL_STATUS_ADDR, 8'h07);
		ctl_pulse(2'b01);
		access(1'b0, THERMAL_STATUS_ADDR, 8'h07);
		access(1'b1, THERMAL_STATUS_ADDR, 8'h07);
		access(1'b0, THERMAL_STATUS_ADDR, 8'h00);
		// Config 0: first failure restarts only
		wd_pulse(3'b001);
		check1(wd_restart, 1'b1);
		check1(fail_out, 1'b0);
		access(1'b0, DEVICE_STATUS_ADDR, 8'h44);
		wd_pulse(3'b001);
		check1(fail_out, 1'b1);
		access(1'b0, DEVICE_STATUS_ADDR, 8'h49);
		wd_pulse(3'b001);
		access(1'b1, DEVICE_STATUS_ADDR, 8'h49);
		access(1'b0, DEVICE_STATUS_ADDR, 8'h08);
		wd_stop_fail = 1'b1;
		wd_pulse(3'b100);
		access(1'b0, DEVICE_STATUS_ADDR, 8'h08);
		wd_stop_fail = 1'b0;
		wd_pulse(3'b100);
		access(1'b0, DEVICE_STATUS_ADDR, 8'h00);
		ctl_pulse(2'b10);
		check1(fail_out, 1'b0);
		// Config 2: one failure activates, counter frozen until good trigger
		config_sel = CONFIG_2;
		wd_pulse(3'b001);
		check1(fail_out, 1'b1);
		access(1'b0, DEVICE_STATUS_ADDR, 8'h45);
		wd_pulse(3'b100);
		access(1'b0, DEVICE_STATUS_ADDR, 8'h45);
		wd_pulse(3'b010);
		access(1'b1, DEVICE_STATUS_ADDR, 8'h41);
		// Event in the clear cycle survives
		fork
			access(1'b1, DEVICE_STATUS_ADDR, 8'h00);
			fire(9'h020);
		join
		access(1'b1, DEVICE_STATUS_ADDR, 8'h02);
		fire(9'h004);
		access(1'b1, DEVICE_STATUS_ADDR, 8'h80);
		fire(9'h008);
		access(1'b1, DEVICE_STATUS_ADDR, 8'h40);
		fire(9'h003);
		access(1'b1, DEVICE_STATUS_ADDR, 8'h40);
		fire(9'h010);
		access(1'b1, DEVICE_STATUS_ADDR, 8'h01);
		// Every LIN and CAN code
		for (int k = 0; k < 4; k++) begin
			@(negedge clk);
			bus_evt = {1'b1, 2'(k), 1'b1, ~2'(k)};
			@(negedge clk);
			bus_evt = '0;
			access(1'b0, BUS_FAULT_STATUS_ADDR, {1'b0, 2'(k), 2'b00, ~2'(k), 1'b0});
		end
		can_low = 1'b1;
		repeat (2) @(negedge clk);
		check1(can_tx_off, 1'b0);
		access(1'b0, BUS_FAULT_STATUS_ADDR, 8'h60);
		can_mode1 = 1'b1;
		repeat (2) @(negedge clk);
		check1(can_tx_off, 1'b1);
		can_low = 1'b0;
		access(1'b1, BUS_FAULT_STATUS_ADDR, 8'h61);
		access(1'b0, BUS_FAULT_STATUS_ADDR, 8'h00);
		access(1'b1, 7'h45, 8'h00);
		// Config 4: second failure activates, a stop cannot clear a frozen count
		config_sel = CONFIG_4;
		wd_pulse(3'b001);
		access(1'b0, DEVICE_STATUS_ADDR, 8'h44);
		wd_pulse(3'b100);
		access(1'b0, DEVICE_STATUS_ADDR, 8'h44);
		wd_pulse(3'b001);
		access(1'b0, DEVICE_STATUS_ADDR, 8'h49);
		ctl_pulse(2'b01);
		access(1'b0, DEVICE_STATUS_ADDR, 8'h49);
		fire(9'h002);
		access(1'b0, DEVICE_STATUS_ADDR, 8'h89);
		wd_pulse(3'b010);
		access(1'b1, DEVICE_STATUS_ADDR, 8'h81);
		fire(9'h1C0);
		ctl_pulse(2'b10);
		access(1'b0, THERMAL_STATUS_ADDR, 8'h00);
		access(1'b0, DEVICE_STATUS_ADDR, 8'h00);
		check1(fail_out, 1'b0);
		give_verdict();
	end

	// Whole run is under two hundred cycles
	initial begin
		#20000;
		error_cnt++;
		give_verdict();
	end
endmodule : sbc_fault_status_regs_tb
